// >>> ddcc_pkg.sv
// Purpose: Shared constants and types for one downconverter channel
// Assumes: Register indices are byte-wide locations, four bytes apart on APB
// Notes: Byte address of a register is four times its index
`default_nettype none
package ddcc_pkg;
    localparam int DDCC_IDX_W = 12;
    localparam logic [11:0] DDCC_IDX_CTRL = 12'h310;
    localparam logic [11:0] DDCC_IDX_ROUTE = 12'h311;
    localparam logic [11:0] DDCC_IDX_FREQ0 = 12'h314;
    localparam logic [11:0] DDCC_IDX_FREQ1 = 12'h315;
    localparam logic [11:0] DDCC_IDX_FREQ2 = 12'h316;
    localparam logic [11:0] DDCC_IDX_FREQ3 = 12'h317;
    localparam logic [11:0] DDCC_IDX_FREQ4 = 12'h318;
    localparam logic [11:0] DDCC_IDX_FREQ5 = 12'h31A;
    localparam logic [11:0] DDCC_IDX_POFS0 = 12'h31D;
    localparam logic [7:0] DDCC_CTRL_RST = 8'h00;
    localparam logic [7:0] DDCC_ROUTE_RST = 8'h00;
    localparam logic [7:0] DDCC_BYTE_RST = 8'h00;
    // Control: [1:0] decimation code, 3 complex-to-real, 2 reserved, [7:4] stored only
    localparam logic [7:0] DDCC_CTRL_WMASK = 8'hFB;
    localparam int DDCC_CTRL_C2R_BIT = 3;
    // Routing: 0 selects I source, 2 selects Q source, others reserved
    localparam logic [7:0] DDCC_ROUTE_WMASK = 8'h05;
    localparam int DDCC_ROUTE_I_BIT = 0;
    localparam int DDCC_ROUTE_Q_BIT = 2;
    localparam logic [1:0] DDCC_DEC_BY2 = 2'h3;
    localparam logic [1:0] DDCC_DEC_BY4 = 2'h0;
    localparam logic [1:0] DDCC_DEC_BY8 = 2'h1;
    localparam logic [1:0] DDCC_DEC_BY16 = 2'h2;
    localparam int DDCC_NSTAGE = 4;
    localparam int DDCC_NCO_W = 48;
    localparam int DDCC_SAMP_W = 16;
    typedef struct packed {
        logic signed [DDCC_SAMP_W-1:0] i;
        logic signed [DDCC_SAMP_W-1:0] q;
    } ddcc_iq_s;
endpackage
`default_nettype wire

// >>> ddcc_nco.sv
// Purpose: Phase accumulator with phase offset for the channel oscillator
// Assumes: One advance per accepted input sample
// Notes: Output phase is accumulator plus offset, registered
`default_nettype none
`timescale 1ns/1ps
module ddcc_nco
    import ddcc_pkg::*;
#(
    parameter int W = DDCC_NCO_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic advance,
    input wire logic [W-1:0] increment,
    input wire logic [W-1:0] offset,
    output logic [W-1:0] acc,
    output logic [W-1:0] phase
);
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic [W-1:0] phase_r;
    logic [W-1:0] phase_nxt;

    always_comb
    begin
        acc_nxt = acc_r;
        if (advance)
        begin
            acc_nxt = acc_r + increment;
        end
        phase_nxt = acc_r + offset;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_r <= '0;
            phase_r <= '0;
        end
        else
        begin
            acc_r <= acc_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign acc = acc_r;
    assign phase = phase_r;
endmodule
`default_nettype wire

// >>> ddcc_halfband.sv
// Purpose: One decimating half-band stage of the cascade
// Assumes: Input valid at most once per clock
// Notes: Pair average stands in for the filter kernel; bypassed when not active
`default_nettype none
`timescale 1ns/1ps
module ddcc_halfband
    import ddcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic dec_en,
    input wire logic in_valid,
    input wire ddcc_iq_s in_data,
    output logic out_valid,
    output ddcc_iq_s out_data
);
    ddcc_iq_s prev_r;
    ddcc_iq_s prev_nxt;
    logic have_r;
    logic have_nxt;
    logic out_valid_r;
    logic out_valid_nxt;
    ddcc_iq_s out_r;
    ddcc_iq_s out_nxt;
    logic signed [DDCC_SAMP_W:0] sum_i;
    logic signed [DDCC_SAMP_W:0] sum_q;

    always_comb
    begin
        sum_i = {prev_r.i[DDCC_SAMP_W-1], prev_r.i} + {in_data.i[DDCC_SAMP_W-1], in_data.i};
        sum_q = {prev_r.q[DDCC_SAMP_W-1], prev_r.q} + {in_data.q[DDCC_SAMP_W-1], in_data.q};
        prev_nxt = prev_r;
        have_nxt = have_r;
        out_valid_nxt = 1'b0;
        out_nxt = out_r;
        if (!active)
        begin
            have_nxt = 1'b0;
            if (in_valid)
            begin
                out_valid_nxt = 1'b1;
                out_nxt = in_data;
            end
        end
        else if (in_valid)
        begin
            prev_nxt = in_data;
            if (!dec_en || have_r)
            begin
                out_valid_nxt = 1'b1;
                out_nxt.i = sum_i[DDCC_SAMP_W:1];
                out_nxt.q = sum_q[DDCC_SAMP_W:1];
                have_nxt = 1'b0;
            end
            else
            begin
                have_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_r <= '0;
            have_r <= 1'b0;
            out_valid_r <= 1'b0;
            out_r <= '0;
        end
        else
        begin
            prev_r <= prev_nxt;
            have_r <= have_nxt;
            out_valid_r <= out_valid_nxt;
            out_r <= out_nxt;
        end
    end

    assign out_valid = out_valid_r;
    assign out_data = out_r;
endmodule
`default_nettype wire

// >>> ddcc_channel.sv
// Purpose: One downconverter channel: input routing, oscillator, half-band cascade
// Assumes: APB slave, one sample per clock at most from converters A and B
// Notes: Registers sit at byte address four times their index
// Operation
// RL1 - With complex output, code 11 decimates by 2, 00 by 4, 01 by 8 and 10 by 16.
// RL2 - With complex-to-real on, the same codes decimate by 1, 2, 4 and 8.
// RL3 - The first half-band stage always runs and higher codes add stages two to four ahead of it.
// RL4 - The decimation field reads zero after reset, selecting stages two and one.
// RL5 - The Q select bit picks converter A when zero and B when one, and resets to zero.
// RL6 - The I select bit picks converter A when zero and B when one, and resets to zero.
// RL7 - The 48-bit frequency word lives in six byte registers, low byte first, all reset to zero.
// RL8 - The accumulator advances by the frequency word on every sample.
// RL9 - A twos complement phase offset, low byte programmable, is added to the accumulator output.
// RL10 - With complex-to-real on, only real I samples leave, made by an extra quarter-rate mix.
// RL11 - Reserved bits of the routing register read zero and ignore writes.
`default_nettype none
`timescale 1ns/1ps
module ddcc_channel
    import ddcc_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_valid,
    input wire logic signed [DDCC_SAMP_W-1:0] adc_a,
    input wire logic signed [DDCC_SAMP_W-1:0] adc_b,
    output logic out_valid,
    output ddcc_iq_s out_data,
    output logic [DDCC_NCO_W-1:0] nco_phase
);
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] route_r, route_nxt;
    logic [DDCC_NCO_W-1:0] freq_r, freq_nxt;
    logic [7:0] pofs_r, pofs_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [DDCC_IDX_W-1:0] idx;
    logic hit;
    logic [7:0] rd_byte;
    logic wr_go;

    assign idx = paddr[DDCC_IDX_W+1:2];
    assign wr_go = psel && penable && pready_r && pwrite;

    always_comb
    begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            DDCC_IDX_CTRL: rd_byte = ctrl_r;
            DDCC_IDX_ROUTE: rd_byte = route_r & DDCC_ROUTE_WMASK; // RL11
            DDCC_IDX_FREQ0: rd_byte = freq_r[7:0];
            DDCC_IDX_FREQ1: rd_byte = freq_r[15:8];
            DDCC_IDX_FREQ2: rd_byte = freq_r[23:16];
            DDCC_IDX_FREQ3: rd_byte = freq_r[31:24];
            DDCC_IDX_FREQ4: rd_byte = freq_r[39:32];
            DDCC_IDX_FREQ5: rd_byte = freq_r[47:40];
            DDCC_IDX_POFS0: rd_byte = pofs_r;
            default: hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:DDCC_IDX_W+2] != '0)
        begin
            hit = 1'b0;
        end
    end

    // Zero-wait slave: answer is formed in the setup cycle and raised for the first access cycle
    always_comb
    begin
        pready_nxt = psel && !penable && !pready_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && !penable)
        begin
            prdata_nxt = {24'h000000, hit ? rd_byte : 8'h00};
            pslverr_nxt = !hit;
        end
    end

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        route_nxt = route_r;
        freq_nxt = freq_r;
        pofs_nxt = pofs_r;
        if (wr_go && !pslverr_r)
        begin
            case (idx)
                DDCC_IDX_CTRL: ctrl_nxt = pwdata[7:0] & DDCC_CTRL_WMASK;
                DDCC_IDX_ROUTE: route_nxt = pwdata[7:0] & DDCC_ROUTE_WMASK; // RL11 RL5 RL6
                DDCC_IDX_FREQ0: freq_nxt[7:0] = pwdata[7:0]; // RL7
                DDCC_IDX_FREQ1: freq_nxt[15:8] = pwdata[7:0];
                DDCC_IDX_FREQ2: freq_nxt[23:16] = pwdata[7:0];
                DDCC_IDX_FREQ3: freq_nxt[31:24] = pwdata[7:0];
                DDCC_IDX_FREQ4: freq_nxt[39:32] = pwdata[7:0];
                DDCC_IDX_FREQ5: freq_nxt[47:40] = pwdata[7:0]; // RL7
                DDCC_IDX_POFS0: pofs_nxt = pwdata[7:0]; // RL9
                default: ctrl_nxt = ctrl_r;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r <= DDCC_CTRL_RST; // RL4
            route_r <= DDCC_ROUTE_RST;
            freq_r <= '0;
            pofs_r <= DDCC_BYTE_RST;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            route_r <= route_nxt;
            freq_r <= freq_nxt;
            pofs_r <= pofs_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Datapath
    logic c2r;
    logic [2:0] nstages;
    logic [2:0] dec_log2;
    ddcc_iq_s sel_r, sel_nxt;
    logic sel_valid_r;
    logic [DDCC_NCO_W-1:0] acc;
    logic [DDCC_NCO_W-1:0] pofs_ext;
    logic [DDCC_NSTAGE:0] st_valid;
    ddcc_iq_s st_data [DDCC_NSTAGE:0];
    logic [1:0] rot_r, rot_nxt;
    logic out_valid_r, out_valid_nxt;
    ddcc_iq_s out_r, out_nxt;

    assign c2r = ctrl_r[DDCC_CTRL_C2R_BIT];
    assign pofs_ext = {{(DDCC_NCO_W-8){pofs_r[7]}}, pofs_r};

    always_comb
    begin
        case (ctrl_r[1:0]) // RL1
            DDCC_DEC_BY2: nstages = 3'd1;
            DDCC_DEC_BY4: nstages = 3'd2;
            DDCC_DEC_BY8: nstages = 3'd3;
            DDCC_DEC_BY16: nstages = 3'd4;
            default: nstages = 3'd2;
        endcase
        dec_log2 = nstages - {2'b00, c2r}; // RL2
    end

    always_comb
    begin
        sel_nxt.i = route_r[DDCC_ROUTE_I_BIT] ? adc_b : adc_a; // RL6
        sel_nxt.q = route_r[DDCC_ROUTE_Q_BIT] ? adc_b : adc_a; // RL5
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sel_r <= '0;
            sel_valid_r <= 1'b0;
        end
        else
        begin
            sel_r <= adc_valid ? sel_nxt : sel_r;
            sel_valid_r <= adc_valid;
        end
    end

    ddcc_nco #(.W(DDCC_NCO_W)) u_nco (
        .clk(clk),
        .rst(rst),
        .advance(adc_valid), // RL8
        .increment(freq_r),
        .offset(pofs_ext), // RL9
        .acc(acc),
        .phase(nco_phase)
    );

    assign st_valid[DDCC_NSTAGE] = sel_valid_r;
    assign st_data[DDCC_NSTAGE] = sel_r;

    // Stage index 0 is the first half-band stage, run last in the cascade
    for (genvar s = 0; s < DDCC_NSTAGE; s++)
    begin : g_hb
        ddcc_halfband u_hb (
            .clk(clk),
            .rst(rst),
            .active(nstages > 3'(s)), // RL3
            .dec_en(!(s == 0 && c2r)), // RL2
            .in_valid(st_valid[s+1]),
            .in_data(st_data[s+1]),
            .out_valid(st_valid[s]),
            .out_data(st_data[s])
        );
    end

    // Quarter-rate rotation: I, -Q, -I, Q gives the real part
    always_comb
    begin
        rot_nxt = rot_r;
        out_valid_nxt = st_valid[0];
        out_nxt = out_r;
        if (st_valid[0])
        begin
            out_nxt = st_data[0];
            if (c2r) // RL10
            begin
                rot_nxt = rot_r + 2'd1;
                out_nxt.q = '0;
                case (rot_r)
                    2'd0: out_nxt.i = st_data[0].i;
                    2'd1: out_nxt.i = -st_data[0].q;
                    2'd2: out_nxt.i = -st_data[0].i;
                    default: out_nxt.i = st_data[0].q;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rot_r <= 2'd0;
            out_valid_r <= 1'b0;
            out_r <= '0;
        end
        else
        begin
            rot_r <= rot_nxt;
            out_valid_r <= out_valid_nxt;
            out_r <= out_nxt;
        end
    end

    assign out_valid = out_valid_r;
    assign out_data = out_r;

    sequence s_wr_freq0;
        psel && penable && pready && pwrite && idx == DDCC_IDX_FREQ0;
    endsequence

    a_dec_code_map: assert property (@(posedge clk) disable iff (rst) // RL1
        !c2r |-> (ctrl_r[1:0] == 2'h3 && dec_log2 == 3'd1)
        || (ctrl_r[1:0] == 2'h0 && dec_log2 == 3'd2)
        || (ctrl_r[1:0] == 2'h1 && dec_log2 == 3'd3)
        || (ctrl_r[1:0] == 2'h2 && dec_log2 == 3'd4))
        else $error("complex decimation ratio wrong");
    a_real_ratio_half: assert property (@(posedge clk) disable iff (rst) // RL2
        c2r && nstages == 3'd1 && sel_valid_r |-> dec_log2 == 3'd0 ##5 out_valid)
        else $error("real decimation ratio not halved");
    a_first_stage_on: assert property (@(posedge clk) disable iff (rst) // RL3
        st_valid[1] && c2r |=> st_valid[0])
        else $error("first stage did not pass sample in real mode");
    a_ctrl_reset_zero: assert property (@(posedge clk) // RL4
        rst |=> ctrl_r[1:0] == 2'h0 && nstages == 3'd2)
        else $error("decimation field not zero after reset");
    a_route_q_src: assert property (@(posedge clk) disable iff (rst) // RL5
        adc_valid |=> sel_r.q == ($past(route_r[2]) ? $past(adc_b) : $past(adc_a)))
        else $error("Q source routed wrong");
    a_route_i_src: assert property (@(posedge clk) disable iff (rst) // RL6
        adc_valid |=> sel_r.i == ($past(route_r[0]) ? $past(adc_b) : $past(adc_a)))
        else $error("I source routed wrong");
    a_freq_byte_wr: assert property (@(posedge clk) disable iff (rst) // RL7
        s_wr_freq0 |=> freq_r[7:0] == $past(pwdata[7:0]) && freq_r[47:8] == $past(freq_r[47:8]))
        else $error("frequency low byte write wrong");
    a_acc_advance: assert property (@(posedge clk) disable iff (rst) // RL8
        adc_valid |=> acc == $past(acc) + $past(freq_r))
        else $error("accumulator did not advance by increment");
    a_phase_offset: assert property (@(posedge clk) disable iff (rst) // RL9
        !adc_valid ##1 !adc_valid |=> nco_phase == $past(acc) + $past(pofs_ext))
        else $error("phase offset not applied");
    a_real_only_i: assert property (@(posedge clk) disable iff (rst) // RL10
        st_valid[0] && c2r |=> out_valid && out_data.q == '0)
        else $error("Q not zero in real mode");
    a_resv_route_zero: assert property (@(posedge clk) disable iff (rst) // RL11
        (route_r & ~DDCC_ROUTE_WMASK) == 8'h00)
        else $error("reserved routing bits set");
endmodule
`default_nettype wire

// >>> ddcc_adc_model.sv
// Purpose: Converter channels A and B feeding samples to the channel
// Assumes: Bench hands over sample values and a send strobe after each edge
// Notes: Between samples the lines toggle so stale data is never mistaken for new
`timescale 1ns/1ps
`default_nettype none
module ddcc_adc_model
    import ddcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire logic signed [DDCC_SAMP_W-1:0] a_in,
    input wire logic signed [DDCC_SAMP_W-1:0] b_in,
    output logic adc_valid,
    output logic signed [DDCC_SAMP_W-1:0] adc_a,
    output logic signed [DDCC_SAMP_W-1:0] adc_b
);
    logic valid_nxt;
    logic signed [DDCC_SAMP_W-1:0] a_nxt;
    logic signed [DDCC_SAMP_W-1:0] b_nxt;
    always_comb
    begin
        valid_nxt = send;
        a_nxt = send ? a_in : ~adc_a;
        b_nxt = send ? b_in : ~adc_b;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            adc_valid <= 1'b0;
            adc_a <= 16'h0000;
            adc_b <= 16'h0000;
        end
        else
        begin
            adc_valid <= valid_nxt;
            adc_a <= a_nxt;
            adc_b <= b_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> ddcc_channel_tb_top.sv
// Purpose: Self-checking bench for one downconverter channel
// Assumes: Zero-wait APB, six-cycle sample latency
// Notes: Expected samples come from a pair-average tree over the routed inputs
`timescale 1ns/1ps
`default_nettype none
module ddcc_channel_tb_top;
    import ddcc_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, adc_valid, out_valid, send;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, rng;
    logic signed [15:0] adc_a, adc_b, a_in, b_in;
    ddcc_iq_s out_data;
    logic [47:0] nco_phase, inc;
    logic [7:0] route_sh, ofs;
    logic err;
    int n_fail, checks, cyc, si[$], sq[$];
    ddcc_iq_s got[$];
    logic [1:0] codes[4] = '{2'h3, 2'h0, 2'h1, 2'h2};
    int dec[4] = '{2, 4, 8, 16};
    ddcc_channel uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_a(adc_a), .adc_b(adc_b), .out_valid(out_valid),
        .out_data(out_data), .nco_phase(nco_phase));
    ddcc_adc_model adc (.clk(clk), .rst(rst), .send(send), .a_in(a_in), .b_in(b_in),
        .adc_valid(adc_valid), .adc_a(adc_a), .adc_b(adc_b));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic int tree(bit use_q, int lo, int n);
        if (n == 1)
            return use_q ? sq[lo] : si[lo];
        return (tree(use_q, lo, n / 2) + tree(use_q, lo + n / 2, n / 2)) >>> 1;
    endfunction
    // Real output j: stage one averages neighbours, then I, -Q, -I, Q rotation
    function automatic logic [15:0] real_i(int j, int g);
        int c;
        int v;
        c = j % 2;
        v = tree(c, j * g, g);
        if (j > 0)
            v = (v + tree(c, (j - 1) * g, g)) >>> 1;
        else
            v = v >>> 1;
        if (j % 4 == 1 || j % 4 == 2)
            v = -v;
        return 16'(v);
    endfunction
    task summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task do_reset();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        si.delete();
        sq.delete();
        got.delete();
    endtask
    task run(input int n);
        int k;
        bit s;
        k = 0;
        while (k < n)
        begin
            @(posedge clk);
            s = rnd() % 3 != 0;
            send <= s;
            a_in <= 16'(rnd());
            b_in <= 16'(rnd());
            if (s)
                k++;
        end
        @(posedge clk);
        send <= 1'b0;
        for (k = 0; k < 300 && got.size() < n; k++)
            @(posedge clk);
        repeat (20) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        if (!rst && adc_valid === 1'b1)
        begin
            si.push_back(route_sh[0] ? int'(adc_b) : int'(adc_a));
            sq.push_back(route_sh[2] ? int'(adc_b) : int'(adc_a));
        end
        if (out_valid === 1'b1)
            got.push_back(out_data);
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
        pwdata = 32'h00000000; send = 1'b0; a_in = 16'h0000; b_in = 16'h0000;
        rng = 32'd26958; route_sh = 8'h00; n_fail = 0; checks = 0; cyc = 0;
        do_reset();
        apb(1'b0, DDCC_IDX_CTRL, 8'h00);
        chk("ctrl reset", rd, 48'h0);
        apb(1'b0, DDCC_IDX_ROUTE, 8'h00);
        chk("route reset", rd, 48'h0);
        apb(1'b1, DDCC_IDX_ROUTE, 8'hFF);
        apb(1'b0, DDCC_IDX_ROUTE, 8'h00);
        chk("route reserved", rd, 48'h5);
        apb(1'b1, 12'h312, 8'hFF);
        chk("unmapped err", err, 48'h1);
        apb(1'b0, 12'h312, 8'h00);
        chk("unmapped read", rd, 48'h0);
        inc = 48'({rnd(), rnd()});
        ofs = 8'(rnd());
        foreach (codes[k])
        begin
            do_reset();
            route_sh = {5'h00, k[1], 1'b0, k[0]};
            apb(1'b1, DDCC_IDX_ROUTE, route_sh);
            apb(1'b1, DDCC_IDX_CTRL, {6'h00, codes[k]});
            run(64);
            chk("complex count", got.size(), 64 / dec[k]);
            foreach (got[j])
            begin
                chk("i sample", 48'(int'(got[j].i)), 48'(tree(0, j * dec[k], dec[k])));
                chk("q sample", 48'(int'(got[j].q)), 48'(tree(1, j * dec[k], dec[k])));
            end
        end
        foreach (codes[k])
        begin
            do_reset();
            route_sh = 8'h00;
            apb(1'b1, DDCC_IDX_CTRL, {4'h0, 1'b1, 1'b0, codes[k]});
            run(32);
            chk("real count", got.size(), 32 / (dec[k] / 2));
            foreach (got[j])
            begin
                chk("real q", got[j].q, 48'h0);
                chk("real i", {32'h0, got[j].i}, {32'h0, real_i(j, dec[k] / 2)});
            end
        end
        do_reset();
        for (int b = 0; b < 6; b++)
        begin
            apb(1'b0, b == 5 ? DDCC_IDX_FREQ5 : DDCC_IDX_FREQ0 + 12'(b), 8'h00);
            chk("freq reset", rd, 48'h0);
            apb(1'b1, b == 5 ? DDCC_IDX_FREQ5 : DDCC_IDX_FREQ0 + 12'(b), inc[8*b+:8]);
            apb(1'b0, b == 5 ? DDCC_IDX_FREQ5 : DDCC_IDX_FREQ0 + 12'(b), 8'h00);
            chk("freq readback", rd, 48'(inc[8*b+:8]));
        end
        apb(1'b1, DDCC_IDX_POFS0, ofs);
        apb(1'b0, DDCC_IDX_POFS0, 8'h00);
        chk("offset readback", rd, 48'(ofs));
        run(37);
        chk("nco phase", nco_phase, 48'(inc * 37) + {{40{ofs[7]}}, ofs});
        summarize();
    end
endmodule
`default_nettype wire
